// file: fsg_top.sv
// Flash security gate: APB registers, session latch and command verdicts
//
// How it works
// [RULE_01] Security-set records flags; they apply from the next session start.
// [RULE_02] Chip-erase lock refuses external chip erase and block erase.
// [RULE_03] Once chip-erase lock is set, no flag can ever be cleared.
// [RULE_04] Writes still run when only the chip-erase lock is active.
// [RULE_05] Block-erase lock refuses external block erase, self path allowed.
// [RULE_06] Write lock refuses external write and block erase, self allowed.
// [RULE_07] Boot lock refuses chip erase and boot-area erase or write.
// [RULE_08] Boot lock is permanent; the boot area stays unwritable.
// [RULE_09] After shipping reset all four locks are inactive.
// [RULE_10] Locks combine freely; the union of restrictions applies.
// [RULE_11] A successful chip erase clears block-erase and write locks.
// [RULE_12] Only external chip erase clears those locks, never self path.
// [RULE_13] Security-set is also accepted from the self-programming path.
// [RULE_14] Any refused command answers negative, never positive.
// [RULE_15] Flags live in nonvolatile store, latched at session start.
`timescale 1ns/1ps
`include "fsg_map.svh"
module fsg_top #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Flash array command
    output logic                   flash_go,
    output fsg_pkg::fsg_op_type    flash_op,
    output logic [ADDR_W-1:0]      flash_addr
);
    import fsg_pkg::*;

    if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
        $error("ADDR_W must lie between 12 and 32");
    end

    logic [31:0]       prdata_r;
    logic              pready_r;
    logic              pslverr_r;
    logic              flash_go_r;
    fsg_op_type        flash_op_r;
    logic [ADDR_W-1:0] flash_addr_r;
    logic [ADDR_W-1:0] addr_r;
    fsg_flags_type     sec_r;
    fsg_flags_type     act_r;
    fsg_flags_type     nv_flags;
    fsg_op_type        cmd_op_r;
    logic              cmd_self_r;
    logic              sess_r;
    logic              done_r;
    logic              ack_r;
    logic              nak_r;
    fsg_state_type     state_r;
    logic              setup;
    logic              wr_acc;
    logic              mapped;
    logic              gate_ok;
    logic              ok;
    logic              evaluating;
    logic              start_wr;
    logic              cmd_wr;
    logic              nv_set;
    logic              nv_clr;
    logic [31:0]       rd_mux;

    // Bus decode: one wait-free access cycle after setup
    assign setup  = psel && !penable && !pready_r;
    assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;
    assign start_wr = wr_acc && (paddr == `FSG_OFF_CTRL) &&
                      pwdata[`FSG_CTRL_START];
    assign cmd_wr = wr_acc && (paddr == `FSG_OFF_CMD);

    always_comb begin
        mapped = 1'b1;
        rd_mux = `FSG_ZERO32;
        case (paddr)
            `FSG_OFF_CTRL: rd_mux = `FSG_ZERO32;
            `FSG_OFF_CMD: begin
                rd_mux[`FSG_CMD_OP_HI:`FSG_CMD_OP_LO] = cmd_op_r;
                rd_mux[`FSG_CMD_SELF] = cmd_self_r;
            end
            `FSG_OFF_ADDR: rd_mux[ADDR_W-1:0] = addr_r;
            `FSG_OFF_SEC:  rd_mux[3:0] = sec_r;
            `FSG_OFF_STAT: begin
                rd_mux[`FSG_STAT_DONE] = done_r;
                rd_mux[`FSG_STAT_ACK]  = ack_r;
                rd_mux[`FSG_STAT_NAK]  = nak_r;
                rd_mux[`FSG_STAT_SESS] = sess_r;
            end
            `FSG_OFF_NV:   rd_mux[3:0] = nv_flags;
            `FSG_OFF_ACT:  rd_mux[3:0] = act_r;
            default:       mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `FSG_ZERO32;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            if (setup) begin
                prdata_r <= pwrite ? `FSG_ZERO32 : rd_mux;
            end
        end
    end

    // Software-written operands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r     <= ADDR_W'(`FSG_ADDR_RST);
            sec_r      <= `FSG_FLAGS_RST;
            cmd_op_r   <= FSG_OP_CHIP;
            cmd_self_r <= 1'b0;
        end else begin
            if (wr_acc && paddr == `FSG_OFF_ADDR) begin
                addr_r <= pwdata[ADDR_W-1:0];
            end
            if (wr_acc && paddr == `FSG_OFF_SEC) begin
                sec_r <= pwdata[3:0];
            end
            if (cmd_wr && state_r == FSG_IDLE) begin
                cmd_op_r <= fsg_op_type'(
                    pwdata[`FSG_CMD_OP_HI:`FSG_CMD_OP_LO]);
                cmd_self_r <= pwdata[`FSG_CMD_SELF];
            end
        end
    end

    // Command sequencing: one cycle from write to verdict
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= FSG_IDLE;
        end else begin
            case (state_r)
                FSG_IDLE: begin
                    if (cmd_wr) begin
                        state_r <= FSG_EVAL;
                    end
                end
                FSG_EVAL: state_r <= FSG_IDLE;
                default:  state_r <= FSG_IDLE;
            endcase
        end
    end

    fsg_gate #(
        .ADDR_W    (ADDR_W)
    ) u_gate (
        .op        (cmd_op_r),
        .self_path (cmd_self_r),
        .addr      (addr_r),
        .act       (act_r),
        .allow     (gate_ok)
    );

    // External commands need an open session; self path does not
    assign evaluating = (state_r == FSG_EVAL);
    assign ok = gate_ok && (cmd_self_r || sess_r);
    assign nv_set = evaluating && ok && cmd_op_r == FSG_OP_SECSET; // [RULE_13]
    assign nv_clr = evaluating && ok && cmd_op_r == FSG_OP_CHIP &&
                    !cmd_self_r;                               // [RULE_12]

    fsg_nv_store u_nv (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_en    (nv_set),
        .set_flags (sec_r),
        .clr_en    (nv_clr),
        .flags     (nv_flags)
    );

    // Flags take hold only here, so a set mid-session has no effect yet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_r  <= `FSG_FLAGS_RST;
            sess_r <= 1'b0;
        end else if (start_wr) begin
            act_r  <= nv_flags;                                // [RULE_15]
            sess_r <= 1'b1;                                    // [RULE_01]
        end
    end

    // Verdict flags; a new command clears the previous verdict
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            ack_r  <= 1'b0;
            nak_r  <= 1'b0;
        end else if (evaluating) begin
            done_r <= 1'b1;
            ack_r  <= ok;
            nak_r  <= !ok;                                     // [RULE_14]
        end else if (cmd_wr && state_r == FSG_IDLE) begin
            done_r <= 1'b0;
            ack_r  <= 1'b0;
            nak_r  <= 1'b0;
        end
    end

    // Flash array runs accepted erase and write commands only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_go_r   <= 1'b0;
            flash_op_r   <= FSG_OP_CHIP;
            flash_addr_r <= ADDR_W'(`FSG_ADDR_RST);
        end else begin
            flash_go_r <= evaluating && ok &&
                          cmd_op_r != FSG_OP_SECSET;           // [RULE_10]
            if (evaluating) begin
                flash_op_r   <= cmd_op_r;
                flash_addr_r <= addr_r;
            end
        end
    end

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign flash_go   = flash_go_r;
    assign flash_op   = flash_op_r;
    assign flash_addr = flash_addr_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic boot_area;
    assign boot_area = addr_r <= ADDR_W'(`FSG_BOOT_LAST);

    chk_ce_refuse_erase: assert property ( // [RULE_02]
        evaluating && !cmd_self_r && act_r[`FSG_FLAG_CE] &&
        cmd_op_r inside {FSG_OP_CHIP, FSG_OP_BLOCK}
        |=> nak_r && !flash_go_r)
        else $error("erase ran under chip-erase lock");

    chk_ce_keeps_write: assert property ( // [RULE_04]
        evaluating && sess_r && act_r == 4'h1 &&
        cmd_op_r == FSG_OP_WRITE |=> ack_r && flash_go_r)
        else $error("write refused under chip-erase lock only");

    chk_be_ext_block: assert property ( // [RULE_05]
        evaluating && act_r[`FSG_FLAG_BE] && cmd_op_r == FSG_OP_BLOCK
        |=> nak_r == !cmd_self_r || (cmd_self_r && boot_area &&
            act_r[`FSG_FLAG_BOOT]))
        else $error("block-erase lock path handling wrong");

    chk_wr_ext_write: assert property ( // [RULE_06]
        evaluating && !cmd_self_r && act_r[`FSG_FLAG_WR] &&
        cmd_op_r inside {FSG_OP_WRITE, FSG_OP_BLOCK} |=> nak_r)
        else $error("external write ran under write lock");

    chk_boot_area: assert property ( // [RULE_07]
        evaluating && act_r[`FSG_FLAG_BOOT] && boot_area &&
        cmd_op_r != FSG_OP_SECSET |=> nak_r && !flash_go_r)
        else $error("boot area touched under boot lock");

    chk_boot_sticky: assert property ( // [RULE_08]
        nv_flags[`FSG_FLAG_BOOT] |=> nv_flags[`FSG_FLAG_BOOT] [*3])
        else $error("boot lock was cleared");

    chk_ce_freeze: assert property ( // [RULE_03]
        nv_flags[`FSG_FLAG_CE] |=>
        (nv_flags & $past(nv_flags)) == $past(nv_flags))
        else $error("flag cleared after chip-erase lock");

    chk_chip_clears: assert property ( // [RULE_11]
        nv_clr && !nv_flags[`FSG_FLAG_CE] |=>
        !nv_flags[`FSG_FLAG_BE] && !nv_flags[`FSG_FLAG_WR])
        else $error("chip erase left locks set");

    chk_session_latch: assert property ( // [RULE_01]
        start_wr |=> act_r == $past(nv_flags) ##1 act_r == $past(act_r))
        else $error("session flags not latched");

    chk_verdict_excl: assert property ( // [RULE_14]
        cmd_wr && state_r == FSG_IDLE |=> ##1 done_r && (ack_r != nak_r))
        else $error("verdict missing or ambiguous");

    chk_self_no_chip: assert property ( // [RULE_12]
        evaluating && cmd_self_r && cmd_op_r == FSG_OP_CHIP
        |=> nak_r && !flash_go_r)
        else $error("chip erase ran from the self path");

    chk_self_no_clear: assert property ( // [RULE_12]
        evaluating && cmd_self_r |=>
        (nv_flags & $past(nv_flags)) == $past(nv_flags))
        else $error("self path cleared a stored lock");

    chk_secset_or: assert property ( // [RULE_13]
        nv_set |=> nv_flags == ($past(nv_flags) | $past(sec_r)))
        else $error("security set did not add the flags");

    chk_secset_ack: assert property ( // [RULE_13]
        evaluating && cmd_op_r == FSG_OP_SECSET &&
        (cmd_self_r || sess_r) |=> ack_r && !flash_go_r)
        else $error("security set refused or started the array");

    chk_no_sess_nak: assert property ( // [RULE_14]
        evaluating && !cmd_self_r && !sess_r |=> nak_r && !flash_go_r)
        else $error("external command ran outside a session");

    chk_go_acked: assert property ( // [RULE_14]
        flash_go_r |-> ack_r && !nak_r)
        else $error("array started without a positive verdict");

    chk_act_stable: assert property ( // [RULE_01]
        !start_wr |=> act_r == $past(act_r))
        else $error("flags in force changed inside a session");

    chk_wr_self_ok: assert property ( // [RULE_06]
        evaluating && cmd_self_r && act_r[`FSG_FLAG_WR] &&
        cmd_op_r == FSG_OP_WRITE && !boot_area |=> ack_r && flash_go_r)
        else $error("self write refused under write lock");

    chk_boot_chip: assert property ( // [RULE_07]
        evaluating && act_r[`FSG_FLAG_BOOT] && cmd_op_r == FSG_OP_CHIP
        |=> nak_r && !flash_go_r)
        else $error("chip erase ran under boot lock");

    chk_ce_self_block: assert property ( // [RULE_02]
        evaluating && cmd_self_r && act_r[`FSG_FLAG_CE] &&
        cmd_op_r == FSG_OP_BLOCK && !boot_area |=> ack_r && flash_go_r)
        else $error("self block erase refused under chip-erase lock");

    cov_secset: cover property (nv_set ##[1:20] start_wr);
    cov_refused: cover property (evaluating ##1 nak_r);
    cov_chip_ok: cover property (nv_clr ##1 flash_go_r);
    cov_frozen_clear: cover property (nv_clr && nv_flags[`FSG_FLAG_CE]);
    cov_self_wr_lock: cover property (
        evaluating && cmd_self_r && act_r[`FSG_FLAG_WR] ##1 ack_r);
endmodule

// file: fsg_map.svh
// Register offsets, field positions and reset values of the security gate
`ifndef FSG_MAP_SVH
`define FSG_MAP_SVH

`define FSG_OFF_CTRL   8'h00
`define FSG_OFF_CMD    8'h04
`define FSG_OFF_ADDR   8'h08
`define FSG_OFF_SEC    8'h0C
`define FSG_OFF_STAT   8'h10
`define FSG_OFF_NV     8'h14
`define FSG_OFF_ACT    8'h18

`define FSG_CTRL_START 0
`define FSG_CMD_OP_LO  0
`define FSG_CMD_OP_HI  1
`define FSG_CMD_SELF   4

`define FSG_FLAG_CE    0
`define FSG_FLAG_BE    1
`define FSG_FLAG_WR    2
`define FSG_FLAG_BOOT  3
`define FSG_FLAGS_RST  4'h0

`define FSG_STAT_DONE  0
`define FSG_STAT_ACK   1
`define FSG_STAT_NAK   2
`define FSG_STAT_SESS  3

`define FSG_BOOT_LAST  16'h0FFF
`define FSG_ADDR_RST   16'h0000
`define FSG_ZERO32     32'h0000_0000

`endif

// file: fsg_pkg.sv
// Types shared by the flash security gate
package fsg_pkg;
    typedef logic [3:0] fsg_flags_type;
    typedef enum logic [1:0] {
        FSG_OP_CHIP,
        FSG_OP_BLOCK,
        FSG_OP_WRITE,
        FSG_OP_SECSET
    } fsg_op_type;
    typedef enum logic [1:0] {
        FSG_IDLE,
        FSG_EVAL
    } fsg_state_type;
endpackage

// file: fsg_nv_store.sv
// Nonvolatile prohibition flags with their set and clear policy
`timescale 1ns/1ps
`include "fsg_map.svh"
module fsg_nv_store (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Update requests
    input  wire logic             set_en,
    input  wire fsg_pkg::fsg_flags_type set_flags,
    input  wire logic             clr_en,
    // Stored flags
    output fsg_pkg::fsg_flags_type flags
);
    import fsg_pkg::*;

    fsg_flags_type flags_r;
    fsg_flags_type flags_nxt;

    always_comb begin
        flags_nxt = flags_r;
        // Setting only adds restrictions; a security set never clears a set bit
        if (set_en) begin
            flags_nxt = flags_r | set_flags;                   // [RULE_10]
        end
        // Chip-erase lock freezes every flag, boot bit is never cleared
        if (clr_en && !flags_r[`FSG_FLAG_CE]) begin           // [RULE_03]
            flags_nxt[`FSG_FLAG_BE] = 1'b0;                    // [RULE_11]
            flags_nxt[`FSG_FLAG_WR] = 1'b0;                    // [RULE_08]
        end
    end

    // Reset stands for the erased shipped state of the storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= `FSG_FLAGS_RST;                         // [RULE_09]
        end else begin
            flags_r <= flags_nxt;                              // [RULE_15]
        end
    end

    assign flags = flags_r;
endmodule

// file: fsg_gate.sv
// Decision whether one flash command may run under the active flags
`timescale 1ns/1ps
`include "fsg_map.svh"
module fsg_gate #(
    parameter int ADDR_W = 16
) (
    // Command
    input  wire fsg_pkg::fsg_op_type    op,
    input  wire logic                   self_path,
    input  wire logic [ADDR_W-1:0]      addr,
    input  wire fsg_pkg::fsg_flags_type act,
    // Verdict
    output logic                        allow
);
    import fsg_pkg::*;

    logic boot_hit;
    logic ce;
    logic be;
    logic wr;

    assign boot_hit = act[`FSG_FLAG_BOOT] &&
                      (addr <= ADDR_W'(`FSG_BOOT_LAST));        // [RULE_07]
    assign ce = act[`FSG_FLAG_CE];
    assign be = act[`FSG_FLAG_BE];
    assign wr = act[`FSG_FLAG_WR];

    always_comb begin
        case (op)
            // Self path has no chip erase; boot lock blocks it outright
            FSG_OP_CHIP: allow = !self_path && !ce &&
                                 !act[`FSG_FLAG_BOOT];         // [RULE_02]
            FSG_OP_BLOCK: allow = self_path ? !boot_hit :       // [RULE_05]
                                  (!ce && !be && !wr && !boot_hit); // [RULE_06]
            FSG_OP_WRITE: allow = self_path ? !boot_hit :       // [RULE_04]
                                  (!wr && !boot_hit);          // [RULE_06]
            FSG_OP_SECSET: allow = 1'b1;                       // [RULE_13]
            default: allow = 1'b0;
        endcase
    end
endmodule

// file: fsg_flash_model.sv
// Flash array stand-in that records every command the gate lets through
`timescale 1ns/1ps
module fsg_flash_model
    import fsg_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Command from the gate
    input  wire logic              flash_go,
    input  wire fsg_op_type        flash_op,
    input  wire logic [ADDR_W-1:0] flash_addr,
    // Record for the bench
    output int                     go_count,
    output fsg_op_type             last_op,
    output logic [ADDR_W-1:0]      last_addr
);
    // Counts clock cycles with go high, so a go held high for two cycles shows up as two runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_count  <= 0;
            last_op   <= FSG_OP_CHIP;
            last_addr <= '0;
        end else if (flash_go === 1'b1) begin
            go_count  <= go_count + 1;
            last_op   <= flash_op;
            last_addr <= flash_addr;
        end
    end
endmodule

// file: flash_security_gate_bench.sv
// Self-checking bench for the flash security gate
`timescale 1ns/1ps
`include "fsg_map.svh"
module flash_security_gate_bench;
    import fsg_pkg::*;
    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        flash_go;
    fsg_op_type  flash_op;
    logic [15:0] flash_addr;
    int          go_count;
    fsg_op_type  last_op;
    logic [15:0] last_addr;
    int          miscompares = 0;
    int          tests_run = 0;
    logic        err;

    fsg_top #(.ADDR_W(16)) dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_go(flash_go), .flash_op(flash_op),
        .flash_addr(flash_addr));
    fsg_flash_model #(.ADDR_W(16)) flash (.pclk(pclk), .presetn(presetn),
        .flash_go(flash_go), .flash_op(flash_op), .flash_addr(flash_addr),
        .go_count(go_count), .last_op(last_op), .last_addr(last_addr));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task close_out;
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp,
             input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask

    // Holds the request until pready is seen high, with a bounded wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(32'h0, 32'h1, "pready timeout");
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task reset_dut;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task session;
        logic [31:0] q;
        apb(1'b1, `FSG_OFF_CTRL, 32'h1, q);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp, "register read");
    endtask

    // Issues one command and judges verdict and array activity
    task cmd(input logic [1:0] op, input logic slf, input logic [15:0] a,
             input logic ok);
        logic [31:0] q;
        int          n;
        n = go_count;
        apb(1'b1, `FSG_OFF_ADDR, {16'h0, a}, q);
        apb(1'b1, `FSG_OFF_CMD, {27'h0, slf, 2'h0, op}, q);
        @(posedge pclk);
        apb(1'b0, `FSG_OFF_STAT, 32'h0, q);
        chk(q & 32'h7, ok ? 32'h3 : 32'h5, "verdict");
        // Security set never starts the array, even when accepted
        chk(32'(go_count - n), {31'h0, ok && op != 2'h3}, "array runs");
        if (ok && op != 2'h3) begin
            chk({14'h0, last_op, last_addr}, {14'h0, op, a}, "array cmd");
        end
    endtask

    task secset(input logic [3:0] f, input logic slf);
        logic [31:0] q;
        apb(1'b1, `FSG_OFF_SEC, {28'h0, f}, q);
        cmd(2'h3, slf, 16'h0, 1'b1);
    endtask

    task t_shipped;
        logic [31:0] q;
        reset_dut();
        rd_chk(`FSG_OFF_NV, 32'h0);
        rd_chk(`FSG_OFF_STAT, 32'h0);
        apb(1'b0, 8'h1C, 32'h0, q);
        chk({31'h0, err}, 32'h1, "unmapped error");
        cmd(2'h2, 1'b0, 16'h1000, 1'b0);
        session();
        rd_chk(`FSG_OFF_STAT, 32'hD);
        rd_chk(`FSG_OFF_ACT, 32'h0);
        cmd(2'h2, 1'b0, 16'h0000, 1'b1);
        cmd(2'h1, 1'b0, 16'h0FFF, 1'b1);
        cmd(2'h0, 1'b0, 16'h0000, 1'b1);
    endtask

    task t_deferred;
        reset_dut();
        session();
        secset(4'h1, 1'b0);
        rd_chk(`FSG_OFF_NV, 32'h1);
        rd_chk(`FSG_OFF_ACT, 32'h0);
        cmd(2'h1, 1'b0, 16'h2000, 1'b1);
        session();
        rd_chk(`FSG_OFF_ACT, 32'h1);
        cmd(2'h0, 1'b0, 16'h0000, 1'b0);
        cmd(2'h1, 1'b0, 16'h2000, 1'b0);
        cmd(2'h2, 1'b0, 16'h2000, 1'b1);
    endtask

    task t_block_lock;
        reset_dut();
        secset(4'h2, 1'b1);
        session();
        cmd(2'h1, 1'b0, 16'h3000, 1'b0);
        cmd(2'h1, 1'b1, 16'h3000, 1'b1);
        cmd(2'h0, 1'b1, 16'h0000, 1'b0);
        rd_chk(`FSG_OFF_NV, 32'h2);
        cmd(2'h0, 1'b0, 16'h0000, 1'b1);
        rd_chk(`FSG_OFF_NV, 32'h0);
    endtask

    task t_write_lock;
        reset_dut();
        session();
        secset(4'h4, 1'b0);
        session();
        cmd(2'h2, 1'b0, 16'h4000, 1'b0);
        cmd(2'h1, 1'b0, 16'h4000, 1'b0);
        cmd(2'h2, 1'b1, 16'h4000, 1'b1);
    endtask

    task t_boot_lock;
        reset_dut();
        secset(4'h8, 1'b1);
        session();
        cmd(2'h0, 1'b0, 16'h1000, 1'b0);
        cmd(2'h1, 1'b0, 16'h0FFF, 1'b0);
        cmd(2'h2, 1'b1, 16'h0000, 1'b0);
        cmd(2'h1, 1'b1, 16'h0FFF, 1'b0);
        cmd(2'h2, 1'b0, 16'h1000, 1'b1);
        cmd(2'h1, 1'b0, 16'h1000, 1'b1);
        rd_chk(`FSG_OFF_NV, 32'h8);
    endtask

    // Chip-erase lock with write lock: union applies, nothing clears
    task t_frozen;
        reset_dut();
        session();
        secset(4'h5, 1'b0);
        // Chip erase still runs this session, yet frozen flags survive it
        cmd(2'h0, 1'b0, 16'h0000, 1'b1);
        rd_chk(`FSG_OFF_NV, 32'h5);
        session();
        cmd(2'h2, 1'b0, 16'h5000, 1'b0);
        cmd(2'h1, 1'b1, 16'h5000, 1'b1);
        cmd(2'h2, 1'b1, 16'h5000, 1'b1);
        cmd(2'h0, 1'b0, 16'h0000, 1'b0);
        rd_chk(`FSG_OFF_NV, 32'h5);
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err = 1'b0;
        // The first test's reset task holds reset for the opening cycles
        t_shipped();
        t_deferred();
        t_block_lock();
        t_write_lock();
        t_boot_lock();
        t_frozen();
        close_out();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        #(100 * 20000);
        miscompares++;
        close_out();
    end
endmodule
